// ==== verilog/eeprom_loader_pkg.sv ====
`default_nettype none
package eeprom_loader_pkg;
  // Clock and EEPROM serial timing.
  localparam int SYS_CLK_NS   = 4;
  localparam int EE_HALF_NS   = 500;
  localparam int EE_HALF_CYC  = (EE_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int EE_ADDR_BITS = 6;
  localparam int WORD_BITS    = 16;
  localparam int FIFO_DEPTH   = 32;
  localparam logic [2:0] EE_READ_CMD = 3'h6;
  // Header layout; the signature value is arbitrary.
  localparam logic [11:0] HDR_SIGNATURE = 12'h0a5c;
  localparam int HDR_SIG_HI = 15;
  localparam int HDR_SIG_LO = 4;
  localparam int HDR_ZONE1  = 3;
  // Function access entry layout.
  localparam int ENT_MORE   = 15;
  localparam int ENT_BAR_HI = 14;
  localparam int ENT_BAR_LO = 12;
  localparam int ENT_WRITE  = 11;
  localparam int ENT_FN_HI  = 10;
  localparam int ENT_FN_LO  = 8;
  localparam int ENT_OFS_HI = 7;
  localparam int ENT_OFS_LO = 0;
  localparam logic [2:0] BAR_REGION0 = 3'h0;
  localparam logic [2:0] BAR_REGION1 = 3'h1;
  localparam logic [2:0] FN_SERIAL   = 3'h0;
  localparam logic [2:0] FN_PARALLEL = 3'h1;
  // Register map.
  localparam logic [7:0] REG_LOCAL_CFG = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_PROGRESS  = 8'h08;
  localparam int CFG_RELOAD = 29;
  localparam int CFG_VALID  = 28;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [31:0] CFG_RW_MASK = 32'hcfff_ffff;
  localparam int ST_BUSY    = 0;
  localparam int ST_HDR_BAD = 1;
  localparam int ST_RSVD    = 2;
  localparam int ST_SKIP    = 3;
  localparam int ST_TRUNC   = 4;
  typedef enum logic [1:0] {RD_IDLE, RD_SHIFT, RD_PUSH, RD_GAP} rd_state_e;
  typedef enum logic [2:0] {P_IDLE, P_HEADER, P_ENTRY, P_DATA, P_ISSUE} parse_state_e;
endpackage
`default_nettype wire

// ==== verilog/eeprom_zone_config_loader.sv ====
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`default_nettype none
module zone_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two.");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign inReady  = (count_reg != (AW + 1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem[rdPtr_reg];
  assign push     = ce && inValid && inReady;
  assign pop      = ce && outReady && outValid;

  // Storage array.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers and count; flush drops all words.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || (ce && flush)) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // zone_word_fifo

module eeprom_zone_config_loader #(
  parameter int          HALF_CYC   = eeprom_loader_pkg::EE_HALF_CYC,
  parameter int          ADDR_BITS  = eeprom_loader_pkg::EE_ADDR_BITS,
  parameter int          FIFO_DEPTH = eeprom_loader_pkg::FIFO_DEPTH,
  parameter logic [11:0] SIGNATURE  = eeprom_loader_pkg::HDR_SIGNATURE
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             eeClk,
  output logic             eeCs,
  output logic             eeDin,
  input  wire logic        eeDout,
  output logic             fnReq,
  output logic             fnWrite,
  output logic [2:0]       fnBar,
  output logic [2:0]       fnFunc,
  output logic [7:0]       fnOffset,
  output logic [7:0]       fnWrData,
  input  wire logic        fnAck,
  output logic             hostRetry
);
  localparam int WB      = eeprom_loader_pkg::WORD_BITS;
  localparam int CMD_LEN = 3 + ADDR_BITS;
  localparam int BITS    = CMD_LEN + WB;
  localparam int HW      = $clog2(HALF_CYC + 1);
  localparam int BW      = $clog2(BITS + 1);
  if (HALF_CYC < 4 || ADDR_BITS < 6 || ADDR_BITS > 10) begin : g_bad_param
    $error("Half period needs four cycles; address bits must be 6 to 10.");
  end

  eeprom_loader_pkg::rd_state_e    rdState_reg;
  eeprom_loader_pkg::parse_state_e pState_reg;
  logic [HW-1:0]        halfCnt_reg;
  logic [BW-1:0]        bitCnt_reg;
  logic [ADDR_BITS-1:0] wordAddr_reg;
  logic [WB-1:0]        shift_reg;
  logic                 eeDoutMeta_reg;
  logic                 eeDoutSync_reg;
  logic                 startReq_reg;
  logic                 validFlag_reg;
  logic [3:0]           zones_reg;
  logic [WB-1:0]        entry_reg;
  logic [7:0]           data_reg;
  logic [15:0]          entryCnt_reg;
  logic [4:1]           flags_reg;
  logic [31:0]          cfgWord_reg;
  logic                 dpWrite_reg;
  logic                 dpRead_reg;
  logic [7:0]           dpAddr_reg;
  logic                 halfDone;
  logic                 lastBit;
  logic                 fifoInValid;
  logic                 fifoInReady;
  logic [WB-1:0]        fifoOut;
  logic                 fifoOutValid;
  logic                 popReady;
  logic                 popWord;
  logic                 sigMatch;
  logic                 rsvdCode;
  logic                 exhausted;
  logic                 finish;
  logic                 cfgWrite;
  logic                 addrPhase;

  // Serial command bit for a given bit index: start, opcode, address.
  function automatic logic cmdBit(input logic [BW-1:0] idx, input logic [ADDR_BITS-1:0] adr);
    logic [CMD_LEN-1:0] cmd;
    cmd = {eeprom_loader_pkg::EE_READ_CMD, adr};
    if (idx < BW'(CMD_LEN)) begin
      return cmd[CMD_LEN - 1 - int'(idx)];
    end
    return 1'b0;
  endfunction

  // Two-stage synchroniser for the EEPROM data pin.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      eeDoutMeta_reg <= 1'b0;
      eeDoutSync_reg <= 1'b0;
    end else if (ce) begin
      eeDoutMeta_reg <= eeDout;
      eeDoutSync_reg <= eeDoutMeta_reg;
    end
  end

  assign halfDone = (halfCnt_reg == HW'(HALF_CYC - 1));
  assign lastBit  = (bitCnt_reg == BW'(BITS - 1));

  // Half-period timer for the serial clock and the inter-word gap.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      halfCnt_reg <= '0;
    end else if (ce) begin
      if (rdState_reg == eeprom_loader_pkg::RD_IDLE || halfDone) begin
        halfCnt_reg <= '0;
      end else if (rdState_reg != eeprom_loader_pkg::RD_PUSH) begin
        halfCnt_reg <= halfCnt_reg + 1'b1;
      end
    end
  end

  // Word reader: one read command per word, words pushed into the FIFO.
  // A full FIFO holds the reader in RD_PUSH, so reading stalls.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdState_reg  <= eeprom_loader_pkg::RD_IDLE;
      bitCnt_reg   <= '0;
      wordAddr_reg <= '0;
      shift_reg    <= '0;
      eeClk        <= 1'b0;
      eeCs         <= 1'b0;
      eeDin        <= 1'b0;
    end else if (ce) begin
      if (startReq_reg) begin
        rdState_reg  <= eeprom_loader_pkg::RD_GAP;
        wordAddr_reg <= '0;
        eeClk        <= 1'b0;
        eeCs         <= 1'b0;
      end else if (finish) begin
        rdState_reg <= eeprom_loader_pkg::RD_IDLE;
        eeClk       <= 1'b0;
        eeCs        <= 1'b0;
      end else begin
        case (rdState_reg)
          eeprom_loader_pkg::RD_GAP: begin
            if (halfDone) begin
              rdState_reg <= eeprom_loader_pkg::RD_SHIFT;
              bitCnt_reg  <= '0;
              eeCs        <= 1'b1;
              eeDin       <= cmdBit('0, wordAddr_reg);
            end
          end
          eeprom_loader_pkg::RD_SHIFT: begin
            if (halfDone && !eeClk) begin
              eeClk <= 1'b1;
            end else if (halfDone) begin
              eeClk <= 1'b0;
              if (bitCnt_reg >= BW'(CMD_LEN)) begin
                shift_reg <= {shift_reg[WB-2:0], eeDoutSync_reg};
              end
              if (lastBit) begin
                rdState_reg <= eeprom_loader_pkg::RD_PUSH;
                eeCs        <= 1'b0;
                eeDin       <= 1'b0;
              end else begin
                bitCnt_reg <= bitCnt_reg + 1'b1;
                eeDin      <= cmdBit(bitCnt_reg + 1'b1, wordAddr_reg);
              end
            end
          end
          eeprom_loader_pkg::RD_PUSH: begin
            if (fifoInReady) begin
              wordAddr_reg <= wordAddr_reg + 1'b1;
              rdState_reg  <= (&wordAddr_reg) ? eeprom_loader_pkg::RD_IDLE
                                              : eeprom_loader_pkg::RD_GAP;
            end
          end
          default: begin
            rdState_reg <= eeprom_loader_pkg::RD_IDLE;
          end
        endcase
      end
    end
  end

  assign fifoInValid = (rdState_reg == eeprom_loader_pkg::RD_PUSH);

  zone_word_fifo #(
    .WIDTH (WB),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .flush    (startReq_reg),
    .inData   (shift_reg),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (popReady)
  );

  // Parser decode of the word at the FIFO head and of the held entry word.
  assign popReady  = !startReq_reg && (pState_reg == eeprom_loader_pkg::P_HEADER ||
                     pState_reg == eeprom_loader_pkg::P_ENTRY ||
                     pState_reg == eeprom_loader_pkg::P_DATA);
  assign popWord   = ce && popReady && fifoOutValid;
  assign sigMatch  = (fifoOut[eeprom_loader_pkg::HDR_SIG_HI:eeprom_loader_pkg::HDR_SIG_LO]
                      == SIGNATURE);
  assign rsvdCode  = !(entry_reg[eeprom_loader_pkg::ENT_BAR_HI:eeprom_loader_pkg::ENT_BAR_LO]
                       inside {eeprom_loader_pkg::BAR_REGION0, eeprom_loader_pkg::BAR_REGION1})
                  || !(entry_reg[eeprom_loader_pkg::ENT_FN_HI:eeprom_loader_pkg::ENT_FN_LO]
                       inside {eeprom_loader_pkg::FN_SERIAL, eeprom_loader_pkg::FN_PARALLEL});
  assign exhausted = popReady && !fifoOutValid && rdState_reg == eeprom_loader_pkg::RD_IDLE;
  assign finish    = ce && !startReq_reg && (exhausted || (pState_reg ==
                     eeprom_loader_pkg::P_HEADER && popWord && (!sigMatch ||
                     !fifoOut[eeprom_loader_pkg::HDR_ZONE1])) || (pState_reg ==
                     eeprom_loader_pkg::P_ENTRY && popWord &&
                     !fifoOut[eeprom_loader_pkg::ENT_MORE]));

  // Zone parser: header, then function access pairs, then stop.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pState_reg    <= eeprom_loader_pkg::P_IDLE;
      validFlag_reg <= 1'b0;
      zones_reg     <= '0;
      entry_reg     <= '0;
      data_reg      <= '0;
      entryCnt_reg  <= '0;
      flags_reg     <= '0;
    end else if (ce) begin
      if (startReq_reg) begin
        pState_reg    <= eeprom_loader_pkg::P_HEADER;
        validFlag_reg <= 1'b0;
        entryCnt_reg  <= '0;
        flags_reg     <= '0;
      end else if (finish) begin
        pState_reg <= eeprom_loader_pkg::P_IDLE;
        if (exhausted) begin
          flags_reg[eeprom_loader_pkg::ST_TRUNC] <= 1'b1;
        end
        if (pState_reg == eeprom_loader_pkg::P_HEADER && popWord) begin
          validFlag_reg <= sigMatch;
          flags_reg[eeprom_loader_pkg::ST_HDR_BAD] <= !sigMatch;
          flags_reg[eeprom_loader_pkg::ST_SKIP] <= sigMatch && (fifoOut[2:0] != 3'h0);
        end else if (pState_reg == eeprom_loader_pkg::P_ENTRY) begin
          flags_reg[eeprom_loader_pkg::ST_SKIP] <= (zones_reg[2:0] != 3'h0);
        end
      end else begin
        case (pState_reg)
          eeprom_loader_pkg::P_HEADER: begin
            if (popWord) begin
              validFlag_reg <= 1'b1;
              zones_reg     <= fifoOut[3:0];
              pState_reg    <= eeprom_loader_pkg::P_ENTRY;
            end
          end
          eeprom_loader_pkg::P_ENTRY: begin
            if (popWord) begin
              entry_reg  <= fifoOut;
              pState_reg <= eeprom_loader_pkg::P_DATA;
            end
          end
          eeprom_loader_pkg::P_DATA: begin
            if (popWord) begin
              data_reg <= fifoOut[7:0];
              if (rsvdCode) begin
                flags_reg[eeprom_loader_pkg::ST_RSVD] <= 1'b1;
                pState_reg <= eeprom_loader_pkg::P_ENTRY;
              end else begin
                pState_reg <= eeprom_loader_pkg::P_ISSUE;
              end
            end
          end
          eeprom_loader_pkg::P_ISSUE: begin
            if (fnAck) begin
              entryCnt_reg <= entryCnt_reg + 1'b1;
              pState_reg   <= eeprom_loader_pkg::P_ENTRY;
            end
          end
          default: begin
            pState_reg <= eeprom_loader_pkg::P_IDLE;
          end
        endcase
      end
    end
  end

  // Function access port; read data is never taken back.
  assign fnReq    = (pState_reg == eeprom_loader_pkg::P_ISSUE);
  assign fnWrite  = entry_reg[eeprom_loader_pkg::ENT_WRITE];
  assign fnBar    = entry_reg[eeprom_loader_pkg::ENT_BAR_HI:eeprom_loader_pkg::ENT_BAR_LO];
  assign fnFunc   = entry_reg[eeprom_loader_pkg::ENT_FN_HI:eeprom_loader_pkg::ENT_FN_LO];
  assign fnOffset = entry_reg[eeprom_loader_pkg::ENT_OFS_HI:eeprom_loader_pkg::ENT_OFS_LO];
  assign fnWrData = data_reg;
  // Host accesses are retried from the load request until the parser is back in P_IDLE.
  assign hostRetry = startReq_reg || (pState_reg != eeprom_loader_pkg::P_IDLE);

  // AHB-Lite slave: zero wait states while enabled, always OKAY.
  assign addrPhase = ce && hsel && htrans[1] && hready;
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dpWrite_reg <= 1'b0;
      dpRead_reg  <= 1'b0;
      dpAddr_reg  <= '0;
    end else if (ce) begin
      dpWrite_reg <= addrPhase && hwrite && (hsize == 3'h2);
      dpRead_reg  <= addrPhase && !hwrite;
      dpAddr_reg  <= haddr[7:0];
    end
  end
  assign cfgWrite = ce && dpWrite_reg && (dpAddr_reg == eeprom_loader_pkg::REG_LOCAL_CFG);

  // Config word storage and reload request; reset itself requests a load.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfgWord_reg  <= eeprom_loader_pkg::CFG_RESET;
      startReq_reg <= 1'b1;
    end else if (ce) begin
      if (cfgWrite) begin
        cfgWord_reg <= hwdata & eeprom_loader_pkg::CFG_RW_MASK;
      end
      startReq_reg <= cfgWrite && hwdata[eeprom_loader_pkg::CFG_RELOAD];
    end
  end

  // Read mux over the registered data-phase address.
  always_comb begin
    hrdata = '0;
    if (dpRead_reg) begin
      case (dpAddr_reg)
        eeprom_loader_pkg::REG_LOCAL_CFG: begin
          hrdata = cfgWord_reg;
          hrdata[eeprom_loader_pkg::CFG_VALID] = validFlag_reg;
        end
        eeprom_loader_pkg::REG_STATUS: begin
          hrdata[4:1] = flags_reg;
          hrdata[eeprom_loader_pkg::ST_BUSY] = hostRetry;
        end
        eeprom_loader_pkg::REG_PROGRESS: begin
          hrdata = {entryCnt_reg, 16'(wordAddr_reg)};
        end
        default: begin
          hrdata = '0;
        end
      endcase
    end
  end

  // Checks.
  chk_hdr_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pState_reg == eeprom_loader_pkg::P_ENTRY) |-> validFlag_reg)
    else $error("Entry parsed without valid header.");
  chk_sig_valid: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pState_reg == eeprom_loader_pkg::P_HEADER && popWord && sigMatch && !startReq_reg)
    |=> validFlag_reg)
    else $error("Valid flag not set on signature.");
  chk_zone1_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pState_reg == eeprom_loader_pkg::P_HEADER && popWord && sigMatch && !startReq_reg)
    |=> (pState_reg == ($past(fifoOut[eeprom_loader_pkg::HDR_ZONE1])
                        ? eeprom_loader_pkg::P_ENTRY : eeprom_loader_pkg::P_IDLE)))
    else $error("Zone 1 presence not honoured.");
  chk_pair_next: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pState_reg == eeprom_loader_pkg::P_ENTRY && popWord && fifoOut[15] && !startReq_reg)
    |=> pState_reg == eeprom_loader_pkg::P_DATA)
    else $error("Second word of pair not expected.");
  chk_term_word: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pState_reg == eeprom_loader_pkg::P_ENTRY && popWord && !fifoOut[15] && !startReq_reg)
    |=> pState_reg == eeprom_loader_pkg::P_IDLE)
    else $error("Termination word did not end zone.");
  chk_codes_ok: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fnReq |-> (fnBar inside {3'h0, 3'h1}) && (fnFunc inside {3'h0, 3'h1}))
    else $error("Reserved code issued.");
  chk_entry_fields: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pState_reg == eeprom_loader_pkg::P_ENTRY && popWord && fifoOut[15] && !startReq_reg)
    |=> fnOffset == $past(fifoOut[7:0]) && fnWrite == $past(fifoOut[11]))
    else $error("Entry fields not carried to access.");
  chk_req_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fnReq && !fnAck && ce && !startReq_reg) |=> fnReq && $stable(fnOffset) && $stable(fnWrData))
    else $error("Access dropped before ack.");
  chk_retry_busy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fnReq || rdState_reg != eeprom_loader_pkg::RD_IDLE) |-> hostRetry)
    else $error("Host not retried during load.");
  chk_load_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (startReq_reg && ce && !sys_rst) |=> pState_reg == eeprom_loader_pkg::P_HEADER && !validFlag_reg)
    else $error("Load did not start.");
  chk_reload_req: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cfgWrite && hwdata[eeprom_loader_pkg::CFG_RELOAD]) |=> startReq_reg ##1 hostRetry)
    else $error("Reload not started.");
  chk_bad_hdr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pState_reg == eeprom_loader_pkg::P_HEADER && popWord && !sigMatch && !startReq_reg)
    |=> !validFlag_reg && pState_reg == eeprom_loader_pkg::P_IDLE && !fnReq)
    else $error("Bad header not rejected.");
  cov_write_access: cover property (@(posedge clk_sys) fnReq && fnAck && fnWrite);
  cov_read_access: cover property (@(posedge clk_sys) fnReq && fnAck && !fnWrite);
  cov_fifo_stall: cover property (@(posedge clk_sys) fifoInValid && !fifoInReady);
endmodule // eeprom_zone_config_loader
`default_nettype wire

// ==== sim/ee_word_model.sv ====
`default_nettype none
// Serial word memory answering read commands with 16 data bits, MSB first.
module ee_word_model #(
  parameter int ADDR_BITS = 6
) (
  input  wire logic clk_sys,
  input  wire logic eeClk,
  input  wire logic eeCs,
  input  wire logic eeDin,
  output var logic  eeDout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [2**ADDR_BITS];
  logic [15:0] word;
  logic [15:0] cmd;
  int          bitNum = 0;
  initial eeDout = 1'b0;
  // Deselected, the line toggles each cycle so no stale bit looks valid.
  always @(posedge clk_sys) if (eeCs !== 1'b1) begin
    bitNum = 0;
    eeDout <= ~eeDout;
  end
  // Command and address shift in, then a dummy zero and the word follow.
  always @(posedge eeClk) if (eeCs === 1'b1) begin
    cmd = {cmd[14:0], eeDin};
    bitNum = bitNum + 1;
    if (bitNum == 3 + ADDR_BITS) begin
      word = mem[cmd[ADDR_BITS-1:0]];
      eeDout <= 1'b0;
    end else if (bitNum > 3 + ADDR_BITS) begin
      eeDout <= word[15];
      word = {word[14:0], 1'b0};
    end
  end
endmodule // ee_word_model
`default_nettype wire

// ==== sim/eeprom_zone_config_loader_bench.sv ====
`default_nettype none
module eeprom_zone_config_loader_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NENT = 6;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        fnAck = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata, rd;
  logic [2:0]  fnBar, fnFunc;
  logic [7:0]  fnOffset, fnWrData;
  logic        hreadyout, eeClk, eeCs, eeDin, eeDout, fnReq, fnWrite, hostRetry;
  logic [22:0] expQ [$];
  logic [22:0] seen;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          dly = 0;
  int          acks = 0;
  eeprom_zone_config_loader #(.HALF_CYC(4)) i_dut (.clk_sys, .sys_rst, .ce(1'b1), .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp(),
    .hrdata, .eeClk, .eeCs, .eeDin, .eeDout, .fnReq, .fnWrite, .fnBar, .fnFunc, .fnOffset,
    .fnWrData, .fnAck, .hostRetry);
  ee_word_model i_ee (.clk_sys, .eeClk, .eeCs, .eeDin, .eeDout);
  // Free running system clock.
  initial forever #2 clk_sys = ~clk_sys;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic results();
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The access that an entry pair should produce; read data is not compared.
  function automatic logic [22:0] exp_of(input logic [15:0] w1, input logic [15:0] w2);
    return {w1[11], w1[14:12], w1[10:8], w1[7:0], w2[7:0] & {8{w1[11]}}};
  endfunction
  // One single word transfer: address phase, then data phase.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
    hsel <= 1'b0;
  endtask
  // Cuts a hung run short.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end
  // Acknowledges function accesses after a random delay and checks their fields.
  // Acknowledge is written once per edge, so no pulse is overwritten.
  always @(posedge clk_sys) begin
    if (fnReq === 1'b1 && fnAck !== 1'b1 && dly == 0) begin
      fnAck <= 1'b1;
      dly = $urandom_range(6);
      acks++;
      seen = {fnWrite, fnBar, fnFunc, fnOffset, fnWrData & {8{fnWrite}}};
      check(hostRetry, 1);
      check(seen, expQ.pop_front());
    end else begin
      fnAck <= 1'b0;
      if (fnReq === 1'b1 && fnAck !== 1'b1) dly--;
    end
  end
  // Builds the image, runs a good load, then a reload with a bad header.
  initial begin
    logic [15:0] w1, w2;
    int          at;
    void'($urandom(24));
    for (int k = 0; k < 64; k++) i_ee.mem[k] = 16'($urandom);
    i_ee.mem[0] = {eeprom_loader_pkg::HDR_SIGNATURE, 4'b1010};
    at = 1;
    for (int i = 0; i < NENT; i++) begin
      // Pair flag, region, direction, function and offset; both accesses kinds occur.
      w1 = {1'b1, 2'b00, 1'($urandom), 1'($urandom), 2'b00, 1'($urandom), 8'($urandom)};
      if (i == 0) w1[7:0] = 8'hff;
      if (i == 0) w1[11] = 1'b1;
      if (i == 1) w1[11] = 1'b0;
      if (i == 2) w1[14:12] = 3'h2;
      if (i == 4) w1[10:8] = 3'h7;
      w2 = 16'($urandom);
      i_ee.mem[at] = w1;
      i_ee.mem[at + 1] = w2;
      at += 2;
      if (i != 2 && i != 4) expQ.push_back(exp_of(w1, w2));
    end
    i_ee.mem[at] = 16'h0000;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(hostRetry, 1);
    while (hostRetry !== 1'b0) @(posedge clk_sys);
    check(acks, NENT - 2);
    ahb(1'b0, 32'h0000_0000, '0, rd);
    check(rd[28], 1);
    ahb(1'b0, 32'h0000_0004, '0, rd);
    check(rd[4:0], 5'h0c);
    ahb(1'b0, 32'h0000_0008, '0, rd);
    check(rd[31:16], NENT - 2);
    ahb(1'b0, 32'h0000_000c, '0, rd);
    check(rd, 0);
    i_ee.mem[0] = {eeprom_loader_pkg::HDR_SIGNATURE ^ 12'h801, 4'b1000};
    ahb(1'b1, 32'h0000_0000, 32'h2000_0000, rd);
    repeat (3) @(posedge clk_sys);
    check(hostRetry, 1);
    while (hostRetry !== 1'b0) @(posedge clk_sys);
    check(acks, NENT - 2);
    ahb(1'b0, 32'h0000_0000, '0, rd);
    check(rd[29:28], 0);
    ahb(1'b0, 32'h0000_0004, '0, rd);
    check(rd[1:0], 2'h2);
    results();
  end
endmodule // eeprom_zone_config_loader_bench
`default_nettype wire
